/* File: design/sdram_address_mux.sv */
// sdram address multiplexer with apb configuration registers
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
module sdram_address_mux (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_valid,
	input wire logic cmd_column,
	input wire logic cmd_area3,
	input wire logic cmd_auto_precharge,
	input wire logic [sdram_mux_pkg::ADDR_W-1:0] cmd_addr,
	output logic [sdram_mux_pkg::ADDR_W-1:0] ext_addr,
	output logic map_valid,
	output logic map_column,
	output logic map_error
);

	// ----------------------------------------------------------------
	// field decoding
	// ----------------------------------------------------------------
	function automatic logic [2:0] area_type(input logic [31:0] cfg);
		return cfg[sdram_mux_pkg::TYPE_LSB +: 3];
	endfunction

	function automatic logic [1:0] bus_width(input logic [31:0] cfg);
		return cfg[sdram_mux_pkg::BUS_W_LSB +: 2];
	endfunction

	function automatic logic [3:0] area_ctrl(input logic [31:0] ctrl, input logic a3);
		return a3 ? ctrl[sdram_mux_pkg::AREA3_CTRL_LSB +: 4] : ctrl[sdram_mux_pkg::ROW_LSB +: 4];
	endfunction

	logic [31:0] area_bus_config_reg [2];
	logic [31:0] dram_control_reg;
	logic [31:0] next_cfg2, next_cfg3, next_ctrl, next_prdata;
	logic next_pready, next_pslverr;
	logic [sdram_mux_pkg::ADDR_W-1:0] next_ext_addr, mapped;
	logic next_map_valid, next_map_column, next_map_error;
	logic [31:0] sel_cfg;
	logic [3:0] sel_ctrl;
	logic [1:0] row_bits_field, column_bits_field, bus_width_field;
	logic sel_sdram, sel_col9, sel_ok;
	logic bus_setup;
	sdram_mux_pkg::cycle_t cycle;

	// ----------------------------------------------------------------
	// apb register file
	// ----------------------------------------------------------------
	assign bus_setup = psel && !penable;

	always_comb begin
		next_cfg2 = area_bus_config_reg[0];
		next_cfg3 = area_bus_config_reg[1];
		next_ctrl = dram_control_reg;
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		next_pready = bus_setup;
		if (bus_setup) begin
			case (paddr)
				sdram_mux_pkg::OFS_AREA2_CFG: begin
					next_prdata = area_bus_config_reg[0];
				end
				sdram_mux_pkg::OFS_AREA3_CFG: begin
					next_prdata = area_bus_config_reg[1];
				end
				sdram_mux_pkg::OFS_DRAM_CTRL: begin
					next_prdata = dram_control_reg;
				end
				sdram_mux_pkg::OFS_STATUS: begin
					next_prdata[sdram_mux_pkg::ST_VALID] = map_valid;
					next_prdata[sdram_mux_pkg::ST_COLUMN] = map_column;
					next_prdata[sdram_mux_pkg::ST_ERROR] = map_error;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
		// write lands at the completing access edge
		if (psel && penable && pready && pwrite && !pslverr) begin
			case (paddr)
				sdram_mux_pkg::OFS_AREA2_CFG: begin
					next_cfg2 = pwdata & sdram_mux_pkg::CFG_MASK;
				end
				sdram_mux_pkg::OFS_AREA3_CFG: begin
					next_cfg3 = pwdata & sdram_mux_pkg::CFG_MASK;
				end
				sdram_mux_pkg::OFS_DRAM_CTRL: begin
					next_ctrl = pwdata & sdram_mux_pkg::CTRL_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			area_bus_config_reg[0] <= sdram_mux_pkg::CFG_RESET;
			area_bus_config_reg[1] <= sdram_mux_pkg::CFG_RESET;
			dram_control_reg <= sdram_mux_pkg::CTRL_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			area_bus_config_reg[0] <= next_cfg2;
			area_bus_config_reg[1] <= next_cfg3;
			dram_control_reg <= next_ctrl;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------------------------------
	// setting check and address mapping
	// ----------------------------------------------------------------
	assign sel_cfg = cmd_area3 ? area_bus_config_reg[1] : area_bus_config_reg[0];
	assign sel_ctrl = area_ctrl(dram_control_reg, cmd_area3);
	assign bus_width_field = bus_width(sel_cfg);
	assign row_bits_field = sel_ctrl[sdram_mux_pkg::ROW_LSB +: 2];
	assign column_bits_field = sel_ctrl[sdram_mux_pkg::COL_LSB +: 2];
	assign sel_sdram = area_type(sel_cfg) == sdram_mux_pkg::TYPE_SDRAM; // [R9]
	assign sel_col9 = column_bits_field == sdram_mux_pkg::COL_9;
	assign sel_ok = sel_sdram && bus_width_field == sdram_mux_pkg::BUS_W32 // [R10]
		&& row_bits_field == sdram_mux_pkg::ROW_12
		&& (sel_col9 || column_bits_field == sdram_mux_pkg::COL_8);
	assign cycle = cmd_column ? sdram_mux_pkg::CYCLE_COLUMN : sdram_mux_pkg::CYCLE_ROW;

	sdram_addr_mapper u_mapper (
		.col9(sel_col9),
		.column_cycle(cmd_column),
		.precharge_level(cmd_auto_precharge),
		.addr(cmd_addr),
		.mapped(mapped)
	);

	always_comb begin
		next_ext_addr = ext_addr;
		next_map_valid = 1'b0;
		next_map_column = map_column;
		next_map_error = 1'b0;
		if (cmd_valid) begin
			next_map_error = !sel_ok;
			if (sel_ok) begin
				next_ext_addr = mapped;
				next_map_valid = 1'b1;
				case (cycle)
					sdram_mux_pkg::CYCLE_ROW: next_map_column = 1'b0; // [R11]
					sdram_mux_pkg::CYCLE_COLUMN: next_map_column = 1'b1; // [R11]
					default: next_map_column = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ext_addr <= '0;
			map_valid <= 1'b0;
			map_column <= 1'b0;
			map_error <= 1'b0;
		end else begin
			ext_addr <= next_ext_addr;
			map_valid <= next_map_valid;
			map_column <= next_map_column;
			map_error <= next_map_error;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_row_req(c9);
		cmd_valid && sel_ok && !cmd_column && sel_col9 == c9;
	endsequence

	sequence s_col_req(c9);
		cmd_valid && sel_ok && cmd_column && sel_col9 == c9;
	endsequence

	property p_row_col8;
		@(posedge clk_sys) disable iff (!reset_n)
		s_row_req(1'b0) |=> map_valid && ext_addr[17:0] == $past(cmd_addr[25:8]);
	endproperty
	a_row_col8: assert property (p_row_col8) else $error("row map 8-col wrong"); // [R1]

	property p_col_same;
		@(posedge clk_sys) disable iff (!reset_n)
		(s_col_req(1'b0) or s_col_req(1'b1)) |=> map_column
			&& ext_addr[11:0] == $past(cmd_addr[11:0]) && ext_addr[13] == $past(cmd_addr[13])
			&& ext_addr[17:16] == $past(cmd_addr[17:16]);
	endproperty
	a_col_same: assert property (p_col_same) else $error("column map wrong"); // [R1]

	property p_bank_col8;
		@(posedge clk_sys) disable iff (!reset_n)
		(s_row_req(1'b0) or s_col_req(1'b0)) |=> ext_addr[15:14] == $past(cmd_addr[23:22]);
	endproperty
	a_bank_col8: assert property (p_bank_col8) else $error("bank 8-col wrong"); // [R2]

	property p_row_col9;
		@(posedge clk_sys) disable iff (!reset_n)
		s_row_req(1'b1) |=> map_valid && ext_addr[16:0] == $past(cmd_addr[25:9])
			&& ext_addr[17] == 1'b0;
	endproperty
	a_row_col9: assert property (p_row_col9) else $error("row map 9-col wrong"); // [R3]

	property p_bank_col9;
		@(posedge clk_sys) disable iff (!reset_n)
		(s_row_req(1'b1) or s_col_req(1'b1)) |=> ext_addr[15:14] == $past(cmd_addr[24:23]);
	endproperty
	a_bank_col9: assert property (p_bank_col9) else $error("bank 9-col wrong"); // [R4]

	property p_precharge;
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_valid && sel_ok && cmd_column |=> ext_addr[12] == $past(cmd_auto_precharge);
	endproperty
	a_precharge: assert property (p_precharge) else $error("pin 12 not precharge level"); // [R5]

	property p_high_pins;
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_valid && sel_ok |=> ext_addr[25:18] == $past(cmd_addr[25:18]);
	endproperty
	a_high_pins: assert property (p_high_pins) else $error("pins 18-25 altered"); // [R8]

	property p_area_type;
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_valid && !sel_sdram |=> !map_valid && map_error && $stable(ext_addr);
	endproperty
	a_area_type: assert property (p_area_type) else $error("non-sdram area mapped"); // [R9]

	property p_bus_width;
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_valid && bus_width_field != sdram_mux_pkg::BUS_W32 |=> !map_valid && map_error;
	endproperty
	a_bus_width: assert property (p_bus_width) else $error("mapped without 32-bit bus"); // [R10]

	property p_cycle_kind;
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_valid && sel_ok |=> map_column == $past(cmd_column);
	endproperty
	a_cycle_kind: assert property (p_cycle_kind) else $error("cycle kind mismatch"); // [R11]

endmodule

/* File: include/sdram_mux_pkg.sv */
// constants and types for the synchronous dram address multiplexer
//
// Summary of operation
// [R1] 12row/8col: row shifts by 8, column same-numbered
// [R2] 12row/8col: bits 22,23 on pins 14,15
// [R3] 12row/9col: row shifts by 9, column same-numbered
// [R4] 12row/9col: bits 23,24 on pins 14,15
// [R5] column cycle: pin 12 carries precharge level
// [R6] 8-column setting suits 1M x 4-bank parts
// [R7] 9-column setting suits 2M x 4-bank parts
// [R8] pins 18 to 25 always pass through
// [R9] mapping only for area type 100
// [R10] bus width field 11 selects 32 bits
// [R11] row with activate, column with read/write
package sdram_mux_pkg;

	localparam int ADDR_W = 26;
	localparam int MUX_PINS = 18;
	localparam int PIN_AP = 12;
	localparam int PIN_BANK0 = 14;
	localparam int PIN_BANK1 = 15;
	localparam int ROW_SHIFT_COL8 = 8;
	localparam int ROW_SHIFT_COL9 = 9;
	localparam int BANK_LO_COL8 = 22;
	localparam int BANK_LO_COL9 = 23;

	localparam logic [2:0] TYPE_SDRAM = 3'h4;
	localparam logic [1:0] BUS_W32 = 2'h3;
	localparam logic [1:0] ROW_12 = 2'h1;
	localparam logic [1:0] COL_8 = 2'h0;
	localparam logic [1:0] COL_9 = 2'h1;

	// register byte offsets
	localparam logic [7:0] OFS_AREA2_CFG = 8'h00;
	localparam logic [7:0] OFS_AREA3_CFG = 8'h04;
	localparam logic [7:0] OFS_DRAM_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// field positions
	localparam int TYPE_LSB = 0;
	localparam int BUS_W_LSB = 4;
	localparam int AREA3_CTRL_LSB = 8;
	localparam int ROW_LSB = 0;
	localparam int COL_LSB = 2;
	localparam int ST_VALID = 0;
	localparam int ST_COLUMN = 1;
	localparam int ST_ERROR = 2;

	localparam logic [31:0] CFG_MASK = 32'h0000_0037;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0F0F;
	localparam logic [31:0] CFG_RESET = 32'h0000_0030;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0101;

	typedef enum logic {CYCLE_ROW, CYCLE_COLUMN} cycle_t;

endpackage

/* File: design/sdram_addr_mapper.sv */
// combinational row/column address mapping for the 32-bit, 12-row settings
`timescale 1ns/10ps
module sdram_addr_mapper (
	input wire logic col9,
	input wire logic column_cycle,
	input wire logic precharge_level,
	input wire logic [sdram_mux_pkg::ADDR_W-1:0] addr,
	output logic [sdram_mux_pkg::ADDR_W-1:0] mapped
);

	logic [sdram_mux_pkg::ADDR_W+8:0] wide;
	logic [sdram_mux_pkg::ADDR_W-1:0] row_map;
	logic [1:0] bank;

	assign wide = {9'h000, addr};
	assign bank = col9 ? addr[sdram_mux_pkg::BANK_LO_COL9 +: 2] :
		addr[sdram_mux_pkg::BANK_LO_COL8 +: 2];

	genvar i;
	generate
		for (i = 0; i < sdram_mux_pkg::MUX_PINS; i++) begin : g_row
			assign row_map[i] = col9 ? wide[i + sdram_mux_pkg::ROW_SHIFT_COL9] :
				wide[i + sdram_mux_pkg::ROW_SHIFT_COL8]; // [R1] [R3]
		end
	endgenerate
	assign row_map[sdram_mux_pkg::ADDR_W-1:sdram_mux_pkg::MUX_PINS] =
		addr[sdram_mux_pkg::ADDR_W-1:sdram_mux_pkg::MUX_PINS]; // [R8]

	always_comb begin
		if (column_cycle) begin
			mapped = addr; // [R1] [R3]
			mapped[sdram_mux_pkg::PIN_AP] = precharge_level; // [R5]
		end else begin
			mapped = row_map;
		end
		mapped[sdram_mux_pkg::PIN_BANK1:sdram_mux_pkg::PIN_BANK0] = bank; // [R2] [R4]
	end

endmodule

/* File: dv/sdram_far_model.sv */
// far-side memory model: latches what the memory sees on its pins
`timescale 1ns/10ps
module sdram_far_model (
	input wire logic clk_sys,
	input wire logic map_valid,
	input wire logic map_column,
	input wire logic col9,
	input wire logic [25:0] ext_addr,
	output logic [1:0] bank,
	output logic [11:0] row,
	output logic [8:0] col,
	output logic ap
);
	// memory pin 0 sits on device pin 2; 4 banks, 12 row bits
	always_ff @(posedge clk_sys) begin
		if (map_valid) begin
			bank <= ext_addr[15:14];
			if (map_column) begin
				col <= col9 ? ext_addr[10:2] : {1'b0, ext_addr[9:2]};
				ap <= ext_addr[12];
			end else begin
				row <= ext_addr[13:2];
			end
		end
	end
endmodule

/* File: dv/sdram_address_mux_bench.sv */
// self-checking bench for the sdram address multiplexer
`timescale 1ns/10ps
module sdram_address_mux_bench;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic cmd_valid = 1'b0;
	logic cmd_column = 1'b0;
	logic cmd_area3 = 1'b0;
	logic cmd_auto_precharge = 1'b0;
	logic [25:0] cmd_addr = 26'h0;
	logic col9 = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, map_valid, map_column, map_error, far_ap;
	logic [25:0] ext_addr;
	logic [1:0] far_bank;
	logic [11:0] far_row;
	logic [8:0] far_col;
	logic [25:0] addrs [2] = '{26'h2A5_C3F1, 26'h15A_3C0E};
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;

	always #50 clk_sys = ~clk_sys;

	sdram_address_mux u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_column(cmd_column),
		.cmd_area3(cmd_area3), .cmd_auto_precharge(cmd_auto_precharge), .cmd_addr(cmd_addr),
		.ext_addr(ext_addr), .map_valid(map_valid), .map_column(map_column),
		.map_error(map_error));
	sdram_far_model u_far (.clk_sys(clk_sys), .map_valid(map_valid), .map_column(map_column),
		.col9(col9), .ext_addr(ext_addr), .bank(far_bank), .row(far_row), .col(far_col),
		.ap(far_ap));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic ok, input string what);
		checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		check(e === 1'b0, "write refused");
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(q === exp && e === ee, "register read");
	endtask

	function automatic logic [25:0] expect_map(logic c9, logic col, logic ap, logic [25:0] a);
		logic [25:0] e;
		e = a;
		if (!col) e[17:0] = c9 ? {1'b0, a[25:9]} : a[25:8];
		else e[12] = ap;
		e[15:14] = c9 ? a[24:23] : a[23:22];
		return e;
	endfunction

	task automatic map(input logic col, input logic c9, input logic ap, input logic [25:0] a);
		cmd_valid <= 1'b1;
		cmd_column <= col;
		cmd_auto_precharge <= ap;
		cmd_addr <= a;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		@(posedge clk_sys);
		check(map_valid === 1'b1 && map_error === 1'b0 && map_column === col, "map flags");
		check(ext_addr === expect_map(c9, col, ap, a), "address pins");
		@(posedge clk_sys);
		check(far_bank === (c9 ? a[24:23] : a[23:22]), "bank at memory");
		if (col) check(far_ap === ap && far_col === (c9 ? a[10:2] : {1'b0, a[9:2]}), "column");
		else check(far_row === (c9 ? a[22:11] : a[21:10]), "row at memory");
	endtask

	task automatic refuse(input logic [25:0] held);
		cmd_valid <= 1'b1;
		cmd_addr <= ~held;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		@(posedge clk_sys);
		check(map_error === 1'b1 && map_valid === 1'b0 && ext_addr === held, "refused map");
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		expect_reg(sdram_mux_pkg::OFS_AREA2_CFG, sdram_mux_pkg::CFG_RESET, 1'b0);
		expect_reg(sdram_mux_pkg::OFS_DRAM_CTRL, sdram_mux_pkg::CTRL_RESET, 1'b0);
		expect_reg(8'h10, 32'h0, 1'b1);
		refuse(26'h0);
	endtask

	task automatic t_col8();
		write_reg(sdram_mux_pkg::OFS_AREA2_CFG, 32'h0000_0034);
		for (int i = 0; i < 2; i++) begin
			map(1'b0, 1'b0, 1'b0, addrs[i]);
			map(1'b1, 1'b0, i[0], addrs[i]);
		end
	endtask

	task automatic t_col9();
		write_reg(sdram_mux_pkg::OFS_AREA3_CFG, 32'h0000_0034);
		write_reg(sdram_mux_pkg::OFS_DRAM_CTRL, 32'h0000_0501);
		expect_reg(sdram_mux_pkg::OFS_DRAM_CTRL, 32'h0000_0501, 1'b0);
		cmd_area3 <= 1'b1;
		col9 <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			map(1'b0, 1'b1, i[0], addrs[i]);
			map(1'b1, 1'b1, ~i[0], addrs[i]);
		end
		expect_reg(sdram_mux_pkg::OFS_STATUS, 32'h0000_0002, 1'b0);
		write_reg(sdram_mux_pkg::OFS_AREA2_CFG, 32'h0000_0024);
		cmd_area3 <= 1'b0;
		refuse(expect_map(1'b1, 1'b1, 1'b0, addrs[1]));
		// 32-bit bus again, but a column width outside 8/9
		write_reg(sdram_mux_pkg::OFS_AREA2_CFG, 32'h0000_0034);
		write_reg(sdram_mux_pkg::OFS_DRAM_CTRL, 32'h0000_0509);
		refuse(expect_map(1'b1, 1'b1, 1'b0, addrs[1]));
	endtask

	task automatic t_mid_reset();
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		check(ext_addr === 26'h0 && map_column === 1'b0 && map_error === 1'b0, "reset outputs");
		expect_reg(sdram_mux_pkg::OFS_AREA3_CFG, sdram_mux_pkg::CFG_RESET, 1'b0);
		expect_reg(sdram_mux_pkg::OFS_DRAM_CTRL, sdram_mux_pkg::CTRL_RESET, 1'b0);
		refuse(26'h0);
		@(posedge clk_sys);
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset();
		t_col8();
		t_col9();
		t_mid_reset();
		complete_run();
	end
endmodule
